// [shared/sram_ctl_pkg.sv]
// Package: constants and carrier types for the flow-through burst SRAM control block
// Summary of operation
// - High clock qualifier freezes access and burst state; synchronisers still run
// - Selected, strobe high, load low starts read
// - Read data from the unregistered core is registered once at the output
// - Drivers on only when drive control low
// - Inactive select with load low deselects device
// - Burst counter serves up to four accesses
// - Counter wraps on two low bits, strap-selected
// - Step input advances counter, ignores selects
// - Write strobe captured only at burst start
// - Selected, strobe low, load low starts write
// - Drivers off during write data portion, except for a write started directly after a read with drive control low
// - Write data captured one qualified edge after address
// - Only masked-in bytes are updated
// - Mask bit n gates byte n and parity n
// - Burst write steps counter, ignores selects
// - New operation accepted every qualified edge
// - Drive control high disables drivers synchronously, three edges later
// - Power-up deselected with drivers off
package sram_ctl_pkg;
  localparam int ADDR_W   = 17;
  localparam int LANES    = 4;
  localparam int DATA_W   = 32;
  localparam int BURST_W  = 2;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic       WRITE_RST = 1'h0;

  // Operation of the access now in its data cycle
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b100
  } op_t;

  // Control pins sampled at a clock edge
  typedef struct packed {
    logic clock_qualifier_n;
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic burst_step_or_load_n;
    logic write_n;
    logic output_drive_n;
    logic burst_order;
  } ctl_t;

  // Common data lines with parity
  typedef struct packed {
    logic [LANES-1:0]  parity_lines;
    logic [DATA_W-1:0] data;
  } word_t;
endpackage

// [verilog/burst_addr.sv]
// Burst address generator for the two low address bits
`timescale 1ns/1ps
`default_nettype none
module burst_addr (
  input  wire logic [1:0] start_i,
  input  wire logic [1:0] count_i,
  input  wire logic       order_i,
  output logic      [1:0] low_o
);
  import sram_ctl_pkg::*;
  // Linear order adds the beat count and wraps inside the four-word block
  wire [1:0] linear_w = 2'(start_i + count_i);
  // Interleaved order flips the starting bits by the beat count
  wire [1:0] inter_w  = start_i ^ count_i;
  // Low order bits of the current beat
  assign low_o = order_i ? inter_w : linear_w;
endmodule
`default_nettype wire

// [verilog/sram_core.sv]
// Storage array with per-lane write and flow-through read
`timescale 1ns/1ps
`default_nettype none
module sram_core #(
  parameter int AW = 17
) (
  input  wire logic                           CLK_I,
  input  wire logic                           we_i,
  input  wire logic [sram_ctl_pkg::LANES-1:0] lane_i,
  input  wire logic [AW-1:0]                  waddr_i,
  input  wire sram_ctl_pkg::word_t            wdata_i,
  input  wire logic [AW-1:0]                  raddr_i,
  output sram_ctl_pkg::word_t                 rdata_o
);
  import sram_ctl_pkg::*;
  logic [8:0] mem_r [LANES][2**AW];
  genvar g;
  // One byte plus parity per lane
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge CLK_I) begin
        if (we_i && lane_i[g]) begin
          mem_r[g][waddr_i] <= {wdata_i.parity_lines[g], wdata_i.data[8*g +: 8]};
        end
      end
      // Unregistered read path
      assign rdata_o.data[8*g +: 8]  = mem_r[g][raddr_i][7:0];
      assign rdata_o.parity_lines[g] = mem_r[g][raddr_i][8];
    end
  endgenerate
endmodule
`default_nettype wire

// [verilog/sram_ctl.sv]
// Top of the flow-through burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module sram_ctl #(
  parameter int AW = sram_ctl_pkg::ADDR_W
) (
  input  wire logic                           CLK_I,
  input  wire logic                           RST_I,
  input  wire sram_ctl_pkg::ctl_t             CTL_I,
  input  wire logic [AW-1:0]                  ADDR_I,
  input  wire logic [sram_ctl_pkg::LANES-1:0] BYTE_LANE_MASK_N_I,
  input  wire sram_ctl_pkg::word_t            DQ_I,
  output sram_ctl_pkg::word_t                 DQ_O,
  output logic                                DQ_OE_O,
  output logic                                BUSY_O
);
  import sram_ctl_pkg::*;

  // Two-stage synchronisers on the control, address, mask and data pins
  ctl_t                 ctl_s1_r, ctl_s2_r;
  logic [AW-1:0]        addr_s1_r, addr_s2_r;
  logic [LANES-1:0]     mask_s1_r, mask_s2_r;
  word_t                dq_s1_r, dq_s2_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctl_s1_r  <= '1;
      ctl_s2_r  <= '1;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      mask_s1_r <= '1;
      mask_s2_r <= '1;
      dq_s1_r   <= '0;
      dq_s2_r   <= '0;
    end else begin
      ctl_s1_r  <= CTL_I;
      ctl_s2_r  <= ctl_s1_r;
      addr_s1_r <= ADDR_I;
      addr_s2_r <= addr_s1_r;
      mask_s1_r <= BYTE_LANE_MASK_N_I;
      mask_s2_r <= mask_s1_r;
      dq_s1_r   <= DQ_I;
      dq_s2_r   <= dq_s1_r;
    end
  end

  // Decoded command of the present edge
  wire qual_w     = ~ctl_s2_r.clock_qualifier_n;
  wire sel_w      = ~ctl_s2_r.chip_select_first_n & ctl_s2_r.chip_select_second
                    & ~ctl_s2_r.chip_select_third_n;
  wire load_w     = ~ctl_s2_r.burst_step_or_load_n;
  wire start_rd_w = qual_w & load_w & sel_w & ctl_s2_r.write_n;
  wire start_wr_w = qual_w & load_w & sel_w & ~ctl_s2_r.write_n;
  wire desel_w    = qual_w & load_w & ~sel_w;
  wire step_w     = qual_w & ~load_w;

  op_t              op_r, op_nxt;
  logic [AW-1:0]    base_r;
  logic [1:0]       count_r;
  logic             wtype_r;
  logic             ord_r;
  logic [1:0]       low_w;
  logic [AW-1:0]    cur_addr_w;
  logic [LANES-1:0] lane_r;
  word_t            rdata_w;
  logic             drive_w;

  // Full address of the current beat
  assign cur_addr_w = {base_r[AW-1:2], low_w};

  // Next operation in the data cycle
  always_comb begin
    op_nxt = op_r;
    case (1'b1)
      start_rd_w: op_nxt = OP_READ;
      start_wr_w: op_nxt = OP_WRITE;
      desel_w:    op_nxt = OP_IDLE;
      step_w:     op_nxt = (op_r == OP_IDLE) ? OP_IDLE
                         : (wtype_r ? OP_WRITE : OP_READ);
      default:    op_nxt = op_r;
    endcase
  end

  // Address, burst count, access type and state
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      op_r    <= OP_IDLE;
      base_r  <= '0;
      count_r <= BURST_RST;
      wtype_r <= WRITE_RST;
      ord_r   <= 1'b1;
      lane_r  <= '0;
    end else if (qual_w) begin
      op_r   <= op_nxt;
      lane_r <= ~mask_s2_r;
      ord_r  <= ctl_s2_r.burst_order;
      if (load_w && sel_w) begin
        base_r  <= addr_s2_r;
        count_r <= BURST_RST;
        wtype_r <= ~ctl_s2_r.write_n;
      end else if (!load_w) begin
        count_r <= 2'(count_r + 2'h1);
      end
    end
  end

  // Write data lands on the next qualified edge after the address edge
  sram_core #(.AW(AW)) u_core (
    .CLK_I   (CLK_I),
    .we_i    (qual_w && op_r == OP_WRITE),
    .lane_i  (lane_r),
    .waddr_i (cur_addr_w),
    .wdata_i (dq_s2_r),
    .raddr_i (cur_addr_w),
    .rdata_o (rdata_w)
  );

  // Low address bits in linear or interleaved order
  burst_addr u_burst_addr (
    .start_i (base_r[1:0]),
    .count_i (count_r),
    .order_i (ord_r),
    .low_o   (low_w)
  );

  // Drivers on only for a read data cycle with drive control low
  assign drive_w = (op_r == OP_READ) && !ctl_s2_r.output_drive_n;

  // Registered outputs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DQ_O    <= '0;
      DQ_OE_O <= 1'b0;
      BUSY_O  <= 1'b0;
    end else begin
      DQ_O    <= rdata_w;
      DQ_OE_O <= qual_w ? drive_w : (DQ_OE_O && !ctl_s2_r.output_drive_n);
      BUSY_O  <= (op_r != OP_IDLE);
    end
  end

  // Checks
  a_freeze_state : assert property (@(posedge CLK_I) disable iff (RST_I)
    !qual_w |=> $stable(op_r) && $stable(count_r)) else $error("state moved");
  a_read_start : assert property (@(posedge CLK_I) disable iff (RST_I)
    start_rd_w |=> op_r == OP_READ) else $error("read not started");
  a_write_start : assert property (@(posedge CLK_I) disable iff (RST_I)
    start_wr_w |=> op_r == OP_WRITE) else $error("write not started");
  a_desel_idle : assert property (@(posedge CLK_I) disable iff (RST_I)
    desel_w |=> op_r == OP_IDLE ##1 1) else $error("no deselect");
  a_step_count : assert property (@(posedge CLK_I) disable iff (RST_I)
    step_w |=> count_r == 2'($past(count_r) + 2'h1)) else $error("no step");
  a_type_kept : assert property (@(posedge CLK_I) disable iff (RST_I)
    step_w |=> $stable(wtype_r)) else $error("type changed");
  a_write_noout : assert property (@(posedge CLK_I) disable iff (RST_I)
    op_r == OP_WRITE && qual_w && op_nxt == OP_WRITE |=> !DQ_OE_O) else $error("drive in write");
  a_load_zero : assert property (@(posedge CLK_I) disable iff (RST_I)
    qual_w && load_w && sel_w |=> count_r == 2'h0) else $error("count not cleared");
  a_read_drive : assert property (@(posedge CLK_I) disable iff (RST_I)
    op_r == OP_READ && qual_w && !ctl_s2_r.output_drive_n |=> DQ_OE_O) else $error("no read drive");
  a_idle_off : assert property (@(posedge CLK_I) disable iff (RST_I)
    op_r == OP_IDLE && qual_w |=> !DQ_OE_O) else $error("drive while deselected");
  a_drive_off : assert property (@(posedge CLK_I) disable iff (RST_I)
    ctl_s2_r.output_drive_n |=> !DQ_OE_O) else $error("drive control ignored");
  c_read    : cover property (@(posedge CLK_I) start_rd_w);
  c_rdburst : cover property (@(posedge CLK_I) start_rd_w ##1 step_w);
  c_wait    : cover property (@(posedge CLK_I) !qual_w ##1 qual_w);
  c_write   : cover property (@(posedge CLK_I) start_wr_w ##1 step_w);
  c_deselct : cover property (@(posedge CLK_I) desel_w);
endmodule
`default_nettype wire

// [verif/bus_master.sv]
// Bus master model that drives the control, address, mask and write data pins
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  input  wire logic            CLK_I,
  output sram_ctl_pkg::ctl_t   CTL_O,
  output logic [16:0]          ADDR_O,
  output logic [3:0]           MASK_O,
  output sram_ctl_pkg::word_t  DQ_O
);
  import sram_ctl_pkg::*;
  logic order = 1'h0;
  initial begin
    CTL_O  = 8'h56;
    ADDR_O = 17'h0;
    MASK_O = 4'hf;
    DQ_O   = 36'h0;
  end
  // One beat a cycle: 0 deselect, 1 read, 2 write, 3 step, 4 wait state
  task automatic beat(input int k, input logic [16:0] a, input logic [3:0] m,
                      input word_t d, input logic dv, input logic oe_n);
    @(negedge CLK_I);
    CTL_O.clock_qualifier_n    <= (k == 4);
    CTL_O.chip_select_first_n  <= (k == 0 || k == 3);
    CTL_O.chip_select_second   <= 1'h1;
    CTL_O.chip_select_third_n  <= 1'h0;
    CTL_O.burst_step_or_load_n <= (k == 3);
    CTL_O.write_n              <= (k != 2);
    CTL_O.output_drive_n       <= oe_n;
    CTL_O.burst_order          <= order;
    ADDR_O <= (k == 3) ? ~ADDR_O : a; // Step beats carry the inverted previous address
    MASK_O <= m;
    DQ_O   <= dv ? d : ~DQ_O;
  endtask
endmodule
`default_nettype wire

// [verif/test_flow_through_burst_sram_control.sv]
// Self-checking testbench of the flow-through burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module test_flow_through_burst_sram_control;
  import sram_ctl_pkg::*;
  logic        CLK_I = 1'h0;
  logic        RST_I = 1'h1;
  ctl_t        ctl;
  logic [16:0] addr;
  logic [3:0]  mask;
  word_t       dq_in;
  word_t       dq_out;
  logic        oe;
  logic        busy;
  int          n_fail = 0;
  int          n_compared = 0;
  always #12.5 CLK_I = ~CLK_I;
  bus_master u_bus_master (.CLK_I(CLK_I), .CTL_O(ctl), .ADDR_O(addr), .MASK_O(mask),
                           .DQ_O(dq_in));
  sram_ctl u_sram_ctl (.CLK_I(CLK_I), .RST_I(RST_I), .CTL_I(ctl), .ADDR_I(addr),
                       .BYTE_LANE_MASK_N_I(mask), .DQ_I(dq_in), .DQ_O(dq_out),
                       .DQ_OE_O(oe), .BUSY_O(busy));
  // Counts one comparison and reports a miss
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // Single write with nw wait states between address and data
  task automatic wr(input logic [16:0] a, input logic [3:0] m, input word_t d, input int nw);
    u_bus_master.beat(2, a, m, d, 1'h0, 1'h0);
    repeat (nw) u_bus_master.beat(4, a + 17'h1, m, ~d, 1'h1, 1'h0);
    u_bus_master.beat(0, a, m, d, 1'h1, 1'h0);
    repeat (2) begin
      u_bus_master.beat(0, a, 4'hf, d, 1'h0, 1'h0);
      check(oe === 1'h0, "drivers on during write");
    end
  endtask
  // Single read, then deselects while the data cycle is watched
  task automatic rd(input logic [16:0] a, input word_t e, input logic oe_n, input int nw);
    logic seen;
    seen = 1'h0;
    u_bus_master.beat(1, a, 4'hf, e, 1'h0, oe_n);
    repeat (nw) u_bus_master.beat(4, a + 17'h1, 4'h0, e, 1'h0, oe_n);
    repeat (6) begin
      u_bus_master.beat(0, a, 4'hf, e, 1'h0, oe_n);
      if (oe === 1'h1) begin
        seen = 1'h1;
        check(dq_out === e, "read data");
        check(busy === 1'h1, "busy in data cycle");
      end
    end
    check(seen === !oe_n, "output drive");
    check(oe === 1'h0, "drivers on after deselect");
  endtask
  // Four-beat burst write from a in the given order, then single reads
  task automatic burst(input logic [16:0] a, input logic ord, input word_t d);
    logic [1:0] lo;
    u_bus_master.order = ord;
    u_bus_master.beat(2, a, 4'h0, d, 1'h0, 1'h0);
    for (int i = 0; i < 4; i++) u_bus_master.beat(i < 3 ? 3 : 0, a, 4'h0, d + i, 1'h1, 1'h0);
    for (int i = 0; i < 4; i++) begin
      lo = ord ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
      rd({a[16:2], lo}, d + i, 1'h0, 0);
    end
  endtask
  task automatic t_reset;
    check(oe === 1'h0 && busy === 1'h0 && dq_out === 36'h0, "reset state");
  endtask
  task automatic t_bytes;
    wr(17'h5, 4'h0, 36'h9a1b2c3d4, 0);
    rd(17'h5, 36'h9a1b2c3d4, 1'h0, 0);
    wr(17'h5, 4'he, 36'h65e4d3c2b, 0);
    rd(17'h5, 36'h8a1b2c32b, 1'h0, 0);
    wr(17'h5, 4'hf, 36'h000000000, 0);
    rd(17'h5, 36'h8a1b2c32b, 1'h0, 0);
  endtask
  task automatic t_wait;
    wr(17'h20, 4'h0, 36'h312345678, 2);
    rd(17'h20, 36'h312345678, 1'h0, 2);
    rd(17'h20, 36'h312345678, 1'h1, 0);
  endtask
  task automatic print_verdict;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge CLK_I);
    @(negedge CLK_I);
    RST_I <= 1'h0;
    t_reset();
    t_bytes();
    t_wait();
    burst(17'h5, 1'h0, 36'h211110000);
    burst(17'h9, 1'h1, 36'h7a5a50000);
    print_verdict();
  end
endmodule
`default_nettype wire
